// ==== shared/aux_cfg.svh ====
`ifndef AUX_CFG_SVH
`define AUX_CFG_SVH
`define CLK_FREQ_HZ 100000000
`define T_SETUP_MS 50
`define T_STROBE_MS 100
`define T_TAIL_MS 50
`define T_EXT_BCD_MS 150
`define T_STAGE_GAP_MS 100
`define M_SLOT_COUNT 7
`define REG_CTRL 8'h00
`define REG_M_PUSH 8'h04
`define REG_S_SPEED 8'h08
`define REG_T_TOOL 8'h0c
`define REG_START 8'h10
`define REG_STATUS 8'h14
`define CTRL_EXT_BIT 0
`define CTRL_FMT_A_BIT 1
`define CTRL_FMT_B_BIT 2
`define M_IN_TABLE_BIT 8
`define M_EXT_BIT 9
`define PEND_BIT 16
`define START_GO_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_COMPL_BIT 2
`define SPEED_MAX 14'h270f
`endif

// ==== shared/aux_pkg.sv ====
`default_nettype none
package aux_pkg;
   typedef enum logic [1:0] {FN_M = 2'h0, FN_S = 2'h1, FN_T = 2'h2} fn_kind_t;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_PICK = 8'h02,
      ST_SETUP = 8'h04,
      ST_STROBE = 8'h08,
      ST_HOLD = 8'h10,
      ST_TAIL = 8'h20,
      ST_DONE = 8'h40,
      ST_GAP = 8'h80
   } seq_state_t;
   typedef struct packed {
      fn_kind_t kind;
      logic ext;
      logic [7:0] code;
   } xfer_t;
   typedef struct packed {
      logic ext;
      logic in_table;
      logic [7:0] code;
   } m_entry_t;
endpackage
`default_nettype wire

// ==== src/aux_function_bcd_handshake.sv ====
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "aux_cfg.svh"
module aux_function_bcd_handshake
   import aux_pkg::*;
#(
   parameter int CLK_PER_MS = `CLK_FREQ_HZ / 1000,
   parameter int M_SLOTS = `M_SLOT_COUNT
) (
   // Clock, reset and clock enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Cabinet link
   input wire logic completion_in,
   output logic [7:0] bcd_out,
   output logic m_strobe,
   output logic s_strobe,
   output logic t_strobe
);

   // ------------------------------------------------------------
   // Constants
   // ------------------------------------------------------------
   localparam int PW = $clog2(CLK_PER_MS + 1);
   localparam int CW = $clog2(M_SLOTS + 1);
   localparam logic [7:0] SETUP_MS = 8'(`T_SETUP_MS);
   localparam logic [7:0] STROBE_MS = 8'(`T_STROBE_MS);
   localparam logic [7:0] SHORT_END_MS = 8'(`T_STROBE_MS + `T_TAIL_MS);
   localparam logic [7:0] EXT_END_MS = 8'(`T_EXT_BCD_MS);
   localparam logic [7:0] GAP_MS = 8'(`T_STAGE_GAP_MS);

   // Lower bounds of the 2-digit speed ranges for codes 40 to 59.
   localparam logic [13:0] LO_TAB [20] = '{
      14'h000a, 14'h000c, 14'h000d, 14'h000e, 14'h0010,
      14'h0012, 14'h0014, 14'h0017, 14'h0019, 14'h001c,
      14'h0020, 14'h0024, 14'h0028, 14'h002d, 14'h0032,
      14'h0038, 14'h003f, 14'h0047, 14'h0050, 14'h005a};
   // Codes 60 to 79; codes 80 to 99 use the same bounds times ten.
   localparam logic [13:0] HI_TAB [20] = '{
      14'h0064, 14'h0070, 14'h007d, 14'h008c, 14'h00a0,
      14'h00b4, 14'h00c8, 14'h00e0, 14'h00fa, 14'h0118,
      14'h013b, 14'h0163, 14'h0190, 14'h01c2, 14'h01f4,
      14'h0230, 14'h0276, 14'h02c6, 14'h0320, 14'h0384};
   // Codes for single-digit speeds, already in BCD.
   localparam logic [7:0] SMALL_TAB [10] = '{
      8'h00, 8'h20, 8'h26, 8'h29, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39};

   function automatic logic [7:0] speed_to_two_digit(input logic [13:0] s);
      logic [6:0] n;
      n = 7'h27;
      for (int i = 0; i < 20; i++) begin
         if (s >= LO_TAB[i]) n = n + 7'h01;
         if (s >= HI_TAB[i]) n = n + 7'h01;
         if (s >= 14'(HI_TAB[i] * 14'h000a)) n = n + 7'h01;
      end
      if (s < 14'h000a) begin
         speed_to_two_digit = SMALL_TAB[s[3:0]];
      end else begin
         speed_to_two_digit = {4'(n / 7'h0a), 4'(n % 7'h0a)};
      end
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [PW-1:0] pre_q;
   logic [7:0] ms_q, t_code_q, bcd_q, tail_lim;
   seq_state_t st_q, st_d;
   xfer_t cur_q, cur_d;
   logic stage_q, stage_d;
   logic take_m, take_s, take_t, blk_end;
   logic [2:0] ctrl_q;
   m_entry_t m_q [M_SLOTS];
   logic [CW-1:0] m_cnt_q, m_idx_q;
   logic [13:0] s_speed_q, s_clamp;
   logic s_pend_q, t_pend_q, done_q, pready_q, pslverr_q;
   logic [31:0] prdata_q, rd_d;
   logic m_strobe_q, s_strobe_q, t_strobe_q;
   logic acc, wr_fire, idle, go, push, tmr_clr, map_d;
   logic fmt_two, fmt_four, drive_d, strobe_d;
   logic [3:0] dig3, dig2, dig1, dig0;

   assign idle = (st_q == ST_IDLE);
   assign acc = psel & penable & ~pready_q;
   assign wr_fire = psel & penable & pready_q & pwrite;
   assign go = wr_fire & (paddr == `REG_START) & pwdata[`START_GO_BIT] & idle;
   assign push = wr_fire & (paddr == `REG_M_PUSH) & idle & (m_cnt_q < CW'(M_SLOTS));
   assign fmt_two = ctrl_q[`CTRL_FMT_A_BIT] & ~ctrl_q[`CTRL_FMT_B_BIT];
   assign fmt_four = ~ctrl_q[`CTRL_FMT_A_BIT] & ctrl_q[`CTRL_FMT_B_BIT];
   assign s_clamp = (s_speed_q > `SPEED_MAX) ? `SPEED_MAX : s_speed_q;
   assign dig3 = 4'(s_clamp / 14'h03e8);
   assign dig2 = 4'((s_clamp / 14'h0064) % 14'h000a);
   assign dig1 = 4'((s_clamp / 14'h000a) % 14'h000a);
   assign dig0 = 4'(s_clamp % 14'h000a);
   assign tail_lim = cur_q.ext ? EXT_END_MS : SHORT_END_MS;

   // ------------------------------------------------------------
   // Millisecond timer
   // ------------------------------------------------------------
   // The prescaler restarts one count ahead, because a state is left one edge after
   // its limit is seen: an N ms limit then ends exactly N * CLK_PER_MS cycles on.
   assign tmr_clr = (st_d != st_q) && (st_d != ST_TAIL);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_q <= '0;
         ms_q <= 8'h00;
      end else if (ce) begin
         if (tmr_clr) begin
            pre_q <= PW'(1);
            ms_q <= 8'h00;
         end else if (pre_q == PW'(CLK_PER_MS - 1)) begin
            pre_q <= '0;
            if (ms_q != 8'hff) ms_q <= ms_q + 8'h01;
         end else begin
            pre_q <= pre_q + PW'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      stage_d = stage_q;
      take_m = 1'b0;
      take_s = 1'b0;
      take_t = 1'b0;
      blk_end = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            if (go) st_d = ST_PICK;
         end
         ST_PICK: begin
            stage_d = 1'b0;
            if (m_idx_q < m_cnt_q) begin
               take_m = 1'b1;
               cur_d.kind = FN_M;
               cur_d.code = m_q[m_idx_q].code;
               cur_d.ext = ctrl_q[`CTRL_EXT_BIT] |
                  (m_q[m_idx_q].in_table & m_q[m_idx_q].ext);
               st_d = ST_SETUP;
            end else if (s_pend_q) begin
               take_s = 1'b1;
               // Analog format sends nothing on the code lines.
               if (fmt_two || fmt_four) begin
                  cur_d.kind = FN_S;
                  cur_d.ext = ctrl_q[`CTRL_EXT_BIT];
                  cur_d.code = fmt_two ? speed_to_two_digit(s_clamp)
                     : {dig3, dig2};
                  st_d = ST_SETUP;
               end
            end else if (t_pend_q) begin
               take_t = 1'b1;
               cur_d.kind = FN_T;
               cur_d.ext = ctrl_q[`CTRL_EXT_BIT];
               cur_d.code = t_code_q;
               st_d = ST_SETUP;
            end else begin
               blk_end = 1'b1;
               st_d = ST_IDLE;
            end
         end
         ST_SETUP: begin
            if (ms_q >= SETUP_MS) st_d = ST_STROBE;
         end
         ST_STROBE: begin
            if (cur_q.ext) begin
               if (!completion_in) st_d = ST_HOLD;
            end else if (ms_q >= STROBE_MS) begin
               st_d = ST_TAIL;
            end
         end
         ST_HOLD: begin
            if (ms_q >= STROBE_MS) st_d = ST_TAIL;
         end
         ST_TAIL: begin
            if (ms_q >= tail_lim) st_d = ST_DONE;
         end
         ST_DONE: begin
            // A completion input that never dropped passes at once.
            if (completion_in) begin
               if (cur_q.kind == FN_S && fmt_four && !stage_q) begin
                  st_d = ST_GAP;
               end else begin
                  st_d = ST_PICK;
               end
            end
         end
         ST_GAP: begin
            if (ms_q >= GAP_MS) begin
               stage_d = 1'b1;
               cur_d.code = {dig1, dig0};
               st_d = ST_SETUP;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         cur_q <= '0;
         stage_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         cur_q <= cur_d;
         stage_q <= stage_d;
      end
   end

   // ------------------------------------------------------------
   // Cabinet outputs
   // ------------------------------------------------------------
   assign drive_d = strobe_d || (st_d == ST_SETUP) || (st_d == ST_TAIL);
   assign strobe_d = (st_d == ST_STROBE) || (st_d == ST_HOLD);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bcd_q <= 8'h00;
         m_strobe_q <= 1'b0;
         s_strobe_q <= 1'b0;
         t_strobe_q <= 1'b0;
      end else if (ce) begin
         bcd_q <= drive_d ? cur_d.code : 8'h00;
         m_strobe_q <= strobe_d && (cur_d.kind == FN_M);
         s_strobe_q <= strobe_d && (cur_d.kind == FN_S);
         t_strobe_q <= strobe_d && (cur_d.kind == FN_T);
      end
   end

   // ------------------------------------------------------------
   // Block contents
   // ------------------------------------------------------------
   // Loading is refused while a block runs, so the sequencer never
   // sees its queue change under it.
   for (genvar i = 0; i < M_SLOTS; i++) begin : g_slot
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            m_q[i] <= '0;
         end else if (ce && push && m_cnt_q == CW'(i)) begin
            m_q[i] <= m_entry_t'(pwdata[`M_EXT_BIT:0]);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         m_cnt_q <= '0;
         m_idx_q <= '0;
         s_speed_q <= 14'h0000;
         s_pend_q <= 1'b0;
         t_code_q <= 8'h00;
         t_pend_q <= 1'b0;
      end else if (ce) begin
         if (blk_end) begin
            m_cnt_q <= '0;
            m_idx_q <= '0;
         end else begin
            if (take_m) m_idx_q <= m_idx_q + CW'(1);
            if (push) m_cnt_q <= m_cnt_q + CW'(1);
         end
         if (take_s) begin
            s_pend_q <= 1'b0;
         end else if (wr_fire && idle && paddr == `REG_S_SPEED) begin
            s_speed_q <= pwdata[13:0];
            s_pend_q <= pwdata[`PEND_BIT];
         end
         if (take_t) begin
            t_pend_q <= 1'b0;
         end else if (wr_fire && idle && paddr == `REG_T_TOOL) begin
            t_code_q <= pwdata[7:0];
            t_pend_q <= pwdata[`PEND_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Control and status
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 3'h0;
      end else if (ce && wr_fire && idle && paddr == `REG_CTRL) begin
         ctrl_q <= pwdata[2:0];
      end
   end

   // The end of a block sets the flag even in the cycle it is cleared.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
      end else if (ce) begin
         if (blk_end) begin
            done_q <= 1'b1;
         end else if (wr_fire && paddr == `REG_STATUS && pwdata[`STAT_DONE_BIT]) begin
            done_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   always_comb begin
      rd_d = 32'h0000_0000;
      map_d = 1'b1;
      case (paddr)
         `REG_CTRL: rd_d[2:0] = ctrl_q;
         `REG_M_PUSH: rd_d[CW-1:0] = m_cnt_q;
         `REG_S_SPEED: begin
            rd_d[13:0] = s_speed_q;
            rd_d[`PEND_BIT] = s_pend_q;
         end
         `REG_T_TOOL: begin
            rd_d[7:0] = t_code_q;
            rd_d[`PEND_BIT] = t_pend_q;
         end
         `REG_START: rd_d = 32'h0000_0000;
         `REG_STATUS: begin
            rd_d[`STAT_BUSY_BIT] = ~idle;
            rd_d[`STAT_DONE_BIT] = done_q;
            rd_d[`STAT_COMPL_BIT] = completion_in;
            rd_d[15:8] = st_q;
            rd_d[16+CW-1:16] = m_idx_q;
         end
         default: map_d = 1'b0;
      endcase
   end

   // One wait state: the answer is registered in the first access cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         pready_q <= acc;
         pslverr_q <= acc & ~map_d;
         if (acc) prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign bcd_out = bcd_q;
   assign m_strobe = m_strobe_q;
   assign s_strobe = s_strobe_q;
   assign t_strobe = t_strobe_q;

endmodule
`default_nettype wire

// ==== testbench/aux_function_bcd_handshake_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module aux_function_bcd_handshake_checker
   import aux_pkg::*;
#(
   parameter int CLK_PER_MS = 100000,
   parameter int M_SLOTS = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Cabinet link
   input wire logic completion_in,
   input wire logic [7:0] bcd_out,
   input wire logic m_strobe,
   input wire logic s_strobe,
   input wire logic t_strobe
);
   localparam int T50 = 50 * CLK_PER_MS;
   localparam int T100 = 100 * CLK_PER_MS;
   logic stb;
   logic on;
   int run_q;
   int hi_q;
   int dn_q;
   assign stb = m_strobe | s_strobe | t_strobe;
   assign on = |bcd_out;
   // ----------------------------------------------------------------
   // Counters follow the clock enable, so a frozen design keeps exact figures.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_q <= 0;
         hi_q <= 0;
         dn_q <= 0;
      end else if (ce) begin
         run_q <= (on && !stb) ? run_q + 1 : 0;
         hi_q <= stb ? hi_q + 1 : 0;
         dn_q <= (stb && (dn_q != 0 || !completion_in)) ? dn_q + 1 : 0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_setup; psel && !penable; endsequence
   sequence s_first; psel && penable && !pready; endsequence
   property p_apb_ready; s_setup ##1 s_first |=> pready; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_slverr; pready |-> pslverr == (paddr > 8'h14); endproperty
   property p_setup; $rose(stb) |-> run_q == T50; endproperty
   property p_tail; $fell(on) |-> run_q == T50 && !stb; endproperty
   property p_len;
      $fell(stb) |-> hi_q == T100 || (dn_q >= T100 && dn_q <= T100 + 2);
   endproperty
   property p_hold; stb |-> on && $stable(bcd_out); endproperty
   property p_one; $onehot0({m_strobe, s_strobe, t_strobe}); endproperty
   property p_wait; !on && !stb && !completion_in |=> !on; endproperty
   property p_reset; $fell(rst) |-> !on && !stb; endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
   a_slverr: assert property (p_slverr) else $error("bad slave error");
   a_setup: assert property (p_setup) else $error("strobe lead wrong");
   a_tail: assert property (p_tail) else $error("code tail wrong");
   a_len: assert property (p_len) else $error("strobe length wrong");
   a_hold: assert property (p_hold) else $error("code moved");
   a_one: assert property (p_one) else $error("two strobes");
   a_wait: assert property (p_wait) else $error("no wait");
   a_reset: assert property (p_reset) else $error("not idle");
endmodule
bind aux_function_bcd_handshake aux_function_bcd_handshake_checker #(
   .CLK_PER_MS(CLK_PER_MS), .M_SLOTS(M_SLOTS)) chk_i (
   .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .completion_in(completion_in), .bcd_out(bcd_out), .m_strobe(m_strobe),
   .s_strobe(s_strobe), .t_strobe(t_strobe));
`default_nettype wire

// ==== testbench/cabinet_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cabinet_model
   import aux_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Cabinet link
   input wire logic [7:0] bcd_out,
   input wire logic m_strobe,
   input wire logic s_strobe,
   input wire logic t_strobe,
   output logic completion_in,
   // Behaviour set by the bench
   input wire logic drop_en,
   input wire logic [15:0] work
);
   xfer_t lg [64];
   int rise [64];
   int hi [64];
   int n;
   int cyc;
   int idle;
   logic stb_q;
   logic pend_q;
   wire logic stb = m_strobe | s_strobe | t_strobe;
   // ----------------------------------------------------------------
   // A slow cabinet keeps completion low for work cycles after the code goes.
   // ----------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         n <= 0;
         cyc <= 0;
         stb_q <= 1'b0;
         pend_q <= 1'b0;
         idle <= 0;
         completion_in <= 1'b1;
      end else begin
         cyc <= cyc + 1;
         stb_q <= stb;
         if (stb && !stb_q) begin
            lg[n] <= '{s_strobe ? FN_S : (t_strobe ? FN_T : FN_M), 1'b0, bcd_out};
            rise[n] <= cyc;
            idle <= 0;
            pend_q <= 1'b1;
            if (drop_en) completion_in <= 1'b0;
         end
         if (!stb && stb_q) begin
            hi[n] <= cyc - rise[n];
            n <= n + 1;
         end
         if (pend_q && !stb && bcd_out == 8'h00) begin
            idle <= idle + 1;
            if (idle == int'(work)) begin
               completion_in <= 1'b1;
               pend_q <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tb_aux_function_bcd_handshake.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "aux_cfg.svh"
module tb_aux_function_bcd_handshake
   import aux_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, completion_in, m_strobe, s_strobe, t_strobe;
   logic [7:0] bcd_out;
   logic drop_en = 1'b0;
   logic [15:0] work = 16'h0;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   int b, t0;
   logic [31:0] r;
   logic e;
   logic [13:0] spd [9] = '{14'h1, 14'h9, 14'ha, 14'h320, 14'h45f, 14'h460, 14'h4d2,
      14'h270f, 14'h2ee0};
   logic [7:0] cod [9] = '{8'h20, 8'h39, 8'h40, 8'h78, 8'h80, 8'h81, 8'h81, 8'h99, 8'h99};
   always #5 clk = ~clk;
   aux_function_bcd_handshake #(.CLK_PER_MS(10)) aux_function_bcd_handshake_i (
      .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .completion_in(completion_in), .bcd_out(bcd_out), .m_strobe(m_strobe),
      .s_strobe(s_strobe), .t_strobe(t_strobe));
   cabinet_model cab_i (.clk(clk), .rst(rst), .bcd_out(bcd_out), .m_strobe(m_strobe),
      .s_strobe(s_strobe), .t_strobe(t_strobe), .completion_in(completion_in),
      .drop_en(drop_en), .work(work));
   task automatic conclude();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkr(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("ERROR %0t timing %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // ----------------------------------------------------------------
   // The master waits for pready with no assumed latency.
   // ----------------------------------------------------------------
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      e = pslverr;
      chkv({31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic fin();
      do apb(`REG_STATUS, 1'b0, 32'h0); while (r[`STAT_DONE_BIT] !== 1'b1);
      apb(`REG_STATUS, 1'b1, 32'h2);
   endtask
   task automatic blk();
      b = cab_i.n;
      apb(`REG_START, 1'b1, 32'h1);
      fin();
   endtask
   task automatic ent(input int i, input fn_kind_t k, input logic [7:0] c);
      xfer_t x;
      x = cab_i.lg[b + i];
      chkv({22'h0, x.kind, x.code}, {22'h0, k, c});
   endtask
   function automatic int hl(input int i);
      return cab_i.hi[b + i];
   endfunction
   function automatic int dr(input int i);
      return cab_i.rise[b + i + 1] - cab_i.rise[b + i];
   endfunction
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chkv({21'h0, bcd_out, m_strobe, s_strobe, t_strobe}, 32'h0);
      apb(`REG_STATUS, 1'b0, 32'h0);
      chkv(r, 32'h104);
      apb(8'h20, 1'b0, 32'h0);
      chkv({31'h0, e}, 32'h1);
      for (int i = 0; i < 9; i++) begin
         apb(`REG_CTRL, 1'b1, 32'h2);
         apb(`REG_S_SPEED, 1'b1, {16'h1, 2'h0, spd[i]});
         blk();
         ent(0, FN_S, cod[i]);
      end
      drop_en <= 1'b1;
      work <= 16'd300;
      apb(`REG_M_PUSH, 1'b1, 32'h41);
      apb(`REG_M_PUSH, 1'b1, 32'h303);
      apb(`REG_M_PUSH, 1'b0, 32'h0);
      chkv(r, 32'h2);
      apb(`REG_S_SPEED, 1'b1, 32'h10320);
      apb(`REG_T_TOOL, 1'b1, 32'h10007);
      blk();
      ent(0, FN_M, 8'h41);
      ent(1, FN_M, 8'h03);
      ent(2, FN_S, 8'h78);
      ent(3, FN_T, 8'h07);
      chkr(hl(0), 1000, 1000);
      chkr(hl(1), 1001, 1100);
      chkr(dr(0), 2300, 2310);
      drop_en <= 1'b0;
      apb(`REG_CTRL, 1'b1, 32'h4);
      apb(`REG_M_PUSH, 1'b1, 32'h122);
      apb(`REG_S_SPEED, 1'b1, 32'h104d2);
      blk();
      ent(0, FN_M, 8'h22);
      ent(1, FN_S, 8'h12);
      ent(2, FN_S, 8'h34);
      chkr(dr(0), 2000, 2006);
      chkr(dr(1), 3000, 3010);
      drop_en <= 1'b1;
      work <= 16'd0;
      apb(`REG_CTRL, 1'b1, 32'h1);
      apb(`REG_T_TOOL, 1'b1, 32'h10056);
      b = cab_i.n;
      t0 = cab_i.cyc;
      apb(`REG_START, 1'b1, 32'h1);
      repeat (100) @(posedge clk);
      ce <= 1'b0;
      repeat (300) @(posedge clk);
      ce <= 1'b1;
      fin();
      ent(0, FN_T, 8'h56);
      chkr(hl(0), 1001, 1100);
      chkr(cab_i.rise[b] - t0, 800, 815);
      apb(`REG_CTRL, 1'b1, 32'h0);
      apb(`REG_S_SPEED, 1'b1, 32'h10320);
      blk();
      chkr(cab_i.n - b, 0, 0);
      conclude();
   end
endmodule
`default_nettype wire
